/* common/scfc_pkg.sv */
// constants for the card interface flag and configuration block
// assumes one 10 MHz system clock and a plain strobe register port
package scfc_pkg;
   // ----------------------------------------
   // register offsets (word index)
   // ----------------------------------------
   localparam logic [3:0] ADDR_CTL   = 4'h0;
   localparam logic [3:0] ADDR_CLK   = 4'h1;
   localparam logic [3:0] ADDR_MODE  = 4'h2;
   localparam logic [3:0] ADDR_RATE  = 4'h3;
   localparam logic [3:0] ADDR_FLAG  = 4'h4;
   localparam logic [3:0] ADDR_INTEN = 4'h5;
   localparam logic [3:0] ADDR_TXD   = 4'h6;
   localparam logic [3:0] ADDR_RXD   = 4'h7;
   // ----------------------------------------
   // control register bits
   // ----------------------------------------
   localparam int CTL_MODULE_ENABLE  = 0;
   localparam int CTL_SRST   = 1;
   localparam int CTL_CLKOUT = 10;
   // ----------------------------------------
   // clock select control fields
   // ----------------------------------------
   localparam int CLK_SRC_LSB = 0;
   localparam int CLK_DIV_LSB = 4;
   localparam int CLK_RUN_IN_DEBUG   = 8;
   localparam logic [1:0] SRC_INTERNAL  = 2'h0;
   localparam logic [1:0] SRC_LOW_SPEED = 2'h1;
   localparam logic [1:0] SRC_HIGH      = 2'h2;
   localparam logic [1:0] SRC_EXTERNAL  = 2'h3;
   localparam logic [1:0] DIV_NONE      = 2'h0;
   // ----------------------------------------
   // line mode config bits
   // ----------------------------------------
   localparam int MODE_MST    = 0;
   localparam int MODE_IDLE_CLOCK_LEVEL = 1;
   localparam int MODE_DRIVE_TYPE  = 2;
   localparam int MODE_DIR    = 4;
   localparam int MODE_INV    = 5;
   localparam int MODE_PRY    = 6;
   localparam int MODE_PRT    = 7;
   localparam logic [7:0] MODE_MASK = 8'hF7;
   localparam logic [7:0] MODE_RST  = 8'h05;
   // ----------------------------------------
   // rate factor
   // ----------------------------------------
   localparam int          RATE_W   = 11;
   localparam logic [10:0] RATE_RST = 11'h173;
   // ----------------------------------------
   // flag and enable bits, status bits
   // ----------------------------------------
   localparam int FL_RX1  = 0;
   localparam int FL_RX2  = 1;
   localparam int FL_OVR  = 2;
   localparam int FL_PAR  = 3;
   localparam int FL_EDT  = 4;
   localparam int FL_TEND = 5;
   localparam int FL_WTE  = 6;
   localparam int FL_TBE  = 7;
   localparam int ST_RX_BUSY = 8;
   localparam int ST_TX_BUSY = 9;
   localparam logic [7:0] FLAG_RST   = 8'h80;
   localparam logic [7:0] FLAG_W1C   = 8'h7C;
   localparam int         RXP_BIT    = 8;
   localparam logic [1:0] FIFO_EMPTY = 2'h0;
   localparam logic [1:0] FIFO_ONE   = 2'h1;
   localparam logic [1:0] FIFO_FULL  = 2'h2;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_SRST = 2'b10
   } scfc_state_t;
endpackage

/* verilog/scfc_core.sv */
// flag, enable and configuration logic of the card interface
// assumes shifters and counters on the same clock drive the event inputs;
// the card data line input is asynchronous and is synchronised here
//
// The implementer's own choices: the register addresses and strobed register access.
module scfc_core
   import scfc_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [15:0] reg_rdata_out,
   input  wire logic        wait_elapsed_in,
   input  wire logic        tx_paused_in,
   input  wire logic        err_signal_in,
   input  wire logic        rx_done_in,
   input  wire logic [7:0]  rx_byte_in,
   input  wire logic        rx_parity_in,
   input  wire logic        tx_load_in,
   input  wire logic        rx_busy_in,
   input  wire logic        tx_busy_in,
   input  wire logic        debug_mode_in,
   input  wire logic        card_clk_in,
   input  wire logic        tx_bit_in,
   input  wire logic        tx_drive_in,
   input  wire logic        data_line_in,
   output logic             irq_out,
   output logic             soft_reset_out,
   output logic [1:0]       clk_src_out,
   output logic [1:0]       clk_div_out,
   output logic             clk_run_out,
   output logic             protocol_t1_out,
   output logic             odd_parity_out,
   output logic             msb_first_out,
   output logic [10:0]      rate_factor_out,
   output logic             etu_tick_out,
   output logic [7:0]       tx_data_out,
   output logic             tx_ready_out,
   output logic             rx_bit_out,
   output logic             data_line_out,
   output logic             data_line_oe_out,
   output logic             card_clock_pin_out,
   output logic             card_clock_pin_oe_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      scfc_state_t       state;
      logic              en;
      logic              clkout;
      logic              run_in_debug;
      logic [1:0]        div;
      logic [1:0]        src;
      logic [7:0]        mode;
      logic [RATE_W-1:0] rate;
      logic [7:0]        flags;
      logic [7:0]        inten;
      logic [7:0]        txbuf;
      logic [8:0]        fifo0;
      logic [8:0]        fifo1;
      logic [1:0]        fcnt;
      logic [15:0]       rdata;
      logic [RATE_W-1:0] etu_cnt;
      logic              etu_tick;
      logic              sync1;
      logic              sync2;
      logic              line_o;
      logic              line_oe;
      logic              cclk_o;
      logic              cclk_oe;
   } scfc_regs_t;

   scfc_regs_t s_q;
   scfc_regs_t s_d;

   // slow sources only run undivided
   function automatic logic [1:0] eff_div(input logic [1:0] src, input logic [1:0] div);
      eff_div = (src == SRC_LOW_SPEED || src == SRC_EXTERNAL) ? DIV_NONE : div;
   endfunction

   function automatic logic wr_at(input logic [3:0] a);
      wr_at = reg_wr_in && (reg_addr_in == a);
   endfunction

   logic wr_ctl;
   logic wr_clk;
   logic wr_mode;
   logic wr_txd;
   logic rd_rxd;
   logic pop;
   logic par_bad;
   logic line_lvl;
   logic [1:0] cnt_after_pop;

   always_comb begin
      wr_ctl        = wr_at(ADDR_CTL);
      wr_clk        = wr_at(ADDR_CLK);
      wr_mode       = wr_at(ADDR_MODE);
      wr_txd        = wr_at(ADDR_TXD);
      rd_rxd        = reg_rd_in && (reg_addr_in == ADDR_RXD);
      pop           = rd_rxd && (s_q.fcnt != FIFO_EMPTY);
      par_bad       = rx_parity_in != ((^rx_byte_in) ^ s_q.mode[MODE_PRY]);
      line_lvl      = tx_bit_in ^ s_q.mode[MODE_INV];
      cnt_after_pop = pop ? s_q.fcnt - 2'h1 : s_q.fcnt;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d          = s_q;
      s_d.rdata    = '0;
      s_d.etu_tick = 1'b0;
      s_d.sync1    = data_line_in;
      s_d.sync2    = s_q.sync1;
      // etu spans rate factor plus one operating clocks
      if (!s_q.en) begin
         s_d.etu_cnt = s_q.rate;
      end else if (s_q.etu_cnt == '0) begin
         s_d.etu_cnt  = s_q.rate;
         s_d.etu_tick = 1'b1;
      end else begin
         s_d.etu_cnt = s_q.etu_cnt - 11'h001;
      end
      unique case (s_q.state)
         ST_SRST: begin
            // events in this cycle are lost to the reset
            s_d.flags = FLAG_RST;
            s_d.fcnt  = FIFO_EMPTY;
            s_d.state = ST_RUN;
         end
         ST_RUN: begin
            if (reg_rd_in) begin
               unique case (reg_addr_in)
                  ADDR_CTL: begin
                     s_d.rdata[CTL_MODULE_ENABLE]  = s_q.en;
                     s_d.rdata[CTL_CLKOUT] = s_q.clkout;
                  end
                  ADDR_CLK: begin
                     s_d.rdata[CLK_SRC_LSB +: 2] = s_q.src;
                     s_d.rdata[CLK_DIV_LSB +: 2] = s_q.div;
                     s_d.rdata[CLK_RUN_IN_DEBUG]        = s_q.run_in_debug;
                  end
                  ADDR_MODE:  s_d.rdata[7:0] = s_q.mode;
                  ADDR_RATE:  s_d.rdata[RATE_W-1:0] = s_q.rate;
                  ADDR_FLAG: begin
                     s_d.rdata[7:0]     = s_q.flags;
                     s_d.rdata[ST_RX_BUSY] = rx_busy_in;
                     s_d.rdata[ST_TX_BUSY] = tx_busy_in;
                  end
                  ADDR_INTEN: s_d.rdata[7:0] = s_q.inten;
                  ADDR_TXD:   s_d.rdata[7:0] = s_q.txbuf;
                  ADDR_RXD:   s_d.rdata[8:0] = s_q.fifo0;
                  default:    s_d.rdata = '0;
               endcase
            end
            if (wr_ctl) begin
               s_d.en     = reg_wdata_in[CTL_MODULE_ENABLE];
               s_d.clkout = reg_wdata_in[CTL_CLKOUT];
               if (reg_wdata_in[CTL_SRST]) begin
                  s_d.state = ST_SRST;
               end
            end
            // locked while enabled so the source never switches under a live clock
            if (wr_clk && !s_q.en) begin
               s_d.src   = reg_wdata_in[CLK_SRC_LSB +: 2];
               s_d.div   = reg_wdata_in[CLK_DIV_LSB +: 2];
               s_d.run_in_debug = reg_wdata_in[CLK_RUN_IN_DEBUG];
            end
            // a change mid-character would corrupt it
            if (wr_mode && !rx_busy_in && !tx_busy_in) begin
               s_d.mode = reg_wdata_in[7:0] & MODE_MASK;
            end
            if (wr_at(ADDR_RATE)) begin
               s_d.rate = reg_wdata_in[RATE_W-1:0];
            end
            if (wr_at(ADDR_INTEN)) begin
               s_d.inten = reg_wdata_in[7:0];
            end
            // write-one clears the flags in FLAG_W1C, zeros leave flags alone
            if (wr_at(ADDR_FLAG)) begin
               s_d.flags = s_q.flags & ~(reg_wdata_in[7:0] & FLAG_W1C);
            end
            if (wr_txd && s_q.en) begin
               s_d.txbuf        = reg_wdata_in[7:0];
               s_d.flags[FL_TBE] = 1'b0;
            end
            // receive buffer, two deep
            s_d.fcnt = cnt_after_pop;
            if (pop) begin
               s_d.fifo0 = s_q.fifo1;
            end
            if (rx_done_in) begin
               if (cnt_after_pop == FIFO_FULL) begin
                  s_d.flags[FL_OVR] = 1'b1;
               end else begin
                  if (cnt_after_pop == FIFO_EMPTY) begin
                     s_d.fifo0 = {rx_parity_in, rx_byte_in};
                  end else begin
                     s_d.fifo1 = {rx_parity_in, rx_byte_in};
                  end
                  s_d.fcnt = cnt_after_pop + 2'h1;
               end
            end
            s_d.flags[FL_RX1] = (s_d.fcnt != FIFO_EMPTY);
            s_d.flags[FL_RX2] = (s_d.fcnt == FIFO_FULL);
            // sets come last so they win over a clear in the same cycle
            if (rx_done_in && par_bad) begin
               s_d.flags[FL_PAR] = 1'b1;
            end
            if (err_signal_in) begin
               s_d.flags[FL_EDT] = 1'b1;
            end
            if (tx_paused_in && s_q.flags[FL_TBE]) begin
               s_d.flags[FL_TEND] = 1'b1;
            end
            if (wait_elapsed_in) begin
               s_d.flags[FL_WTE] = 1'b1;
            end
            if (tx_load_in) begin
               s_d.flags[FL_TBE] = 1'b1;
            end
         end
         default: s_d.state = ST_RUN;
      endcase
      // ----------------------------------------
      // pins, one cycle behind the shifter
      // ----------------------------------------
      if (s_q.mode[MODE_DRIVE_TYPE]) begin
         s_d.line_o  = 1'b0;
         s_d.line_oe = tx_drive_in && !line_lvl;
      end else begin
         s_d.line_o  = line_lvl;
         s_d.line_oe = tx_drive_in;
      end
      s_d.cclk_oe = s_q.mode[MODE_MST];
      s_d.cclk_o  = s_q.clkout ? card_clk_in : s_q.mode[MODE_IDLE_CLOCK_LEVEL];
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_q         <= '0;
         s_q.state   <= ST_RUN;
         s_q.mode    <= MODE_RST;
         s_q.rate    <= RATE_RST;
         s_q.etu_cnt <= RATE_RST;
         s_q.flags   <= FLAG_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign irq_out               = |(s_q.flags & s_q.inten);
   assign reg_rdata_out         = s_q.rdata;
   assign soft_reset_out        = (s_q.state == ST_SRST);
   assign clk_src_out           = s_q.src;
   assign clk_div_out           = eff_div(s_q.src, s_q.div);
   assign clk_run_out           = s_q.en && (!debug_mode_in || s_q.run_in_debug);
   assign protocol_t1_out       = s_q.mode[MODE_PRT];
   assign odd_parity_out        = s_q.mode[MODE_PRY];
   assign msb_first_out         = s_q.mode[MODE_DIR];
   assign rate_factor_out       = s_q.rate;
   assign etu_tick_out          = s_q.etu_tick;
   assign tx_data_out           = s_q.txbuf;
   assign tx_ready_out          = !s_q.flags[FL_TBE];
   assign rx_bit_out            = s_q.sync2 ^ s_q.mode[MODE_INV];
   assign data_line_out         = s_q.line_o;
   assign data_line_oe_out      = s_q.line_oe;
   assign card_clock_pin_out    = s_q.cclk_o;
   assign card_clock_pin_oe_out = s_q.cclk_oe;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   logic run_q;
   assign run_q = (s_q.state == ST_RUN);

   sequence srst_req;
      run_q && wr_ctl && reg_wdata_in[CTL_SRST];
   endsequence
   sequence srst_done;
      soft_reset_out ##1 (!soft_reset_out && s_q.flags == FLAG_RST);
   endsequence

   a_irq_gate_on: assert property ((s_q.flags & s_q.inten) != 8'h00 |-> irq_out)
      else $error("enabled flag set but no request");
   a_irq_gate_off: assert property ((s_q.flags & s_q.inten) == 8'h00 |-> !irq_out)
      else $error("request without enabled flag");
   a_srst_clears: assert property (srst_req |=> srst_done)
      else $error("soft reset did not clear flags and self-clear");
   a_wait_flag: assert property (run_q && wait_elapsed_in |=> s_q.flags[FL_WTE])
      else $error("wait timeout flag not set");
   a_tend_flag: assert property (run_q && tx_paused_in && s_q.flags[FL_TBE]
                                 |=> s_q.flags[FL_TEND])
      else $error("transmit finished flag not set");
   a_edt_flag: assert property (run_q && err_signal_in |=> s_q.flags[FL_EDT])
      else $error("error signal flag not set");
   a_parity_flag: assert property (run_q && rx_done_in && par_bad |=> s_q.flags[FL_PAR])
      else $error("parity flag not set on mismatch");
   a_overrun_set: assert property (run_q && rx_done_in && s_q.fcnt == FIFO_FULL && !pop
                                   |=> s_q.flags[FL_OVR] && s_q.flags[FL_RX2])
      else $error("overrun not flagged on full buffer");
   a_rx_two: assert property (run_q && rx_done_in && s_q.fcnt == FIFO_ONE && !pop
                              |=> s_q.flags[FL_RX2] && s_q.flags[FL_RX1])
      else $error("two byte flag not set");
   a_rx_one: assert property (run_q && rx_done_in && s_q.fcnt == FIFO_EMPTY
                              |=> s_q.flags[FL_RX1] && !s_q.flags[FL_RX2])
      else $error("one byte flag wrong");
   a_rx_drain: assert property (run_q && pop && s_q.fcnt == FIFO_ONE && !rx_done_in
                                |=> !s_q.flags[FL_RX1])
      else $error("one byte flag kept after buffer emptied");
   a_tbe_clear: assert property (run_q && wr_txd && s_q.en && !tx_load_in
                                 |=> tx_ready_out)
      else $error("data write did not clear buffer empty");
   a_w1c_zero: assert property (run_q && wr_at(ADDR_FLAG) && !reg_wdata_in[FL_TEND]
                                && s_q.flags[FL_TEND] |=> s_q.flags[FL_TEND])
      else $error("written zero cleared a flag");
   a_clk_locked: assert property (s_q.en && wr_clk |=> $stable(clk_src_out))
      else $error("clock source changed while enabled");
   a_mode_busy: assert property ((rx_busy_in || tx_busy_in) && wr_mode
                                 |=> $stable(protocol_t1_out) && $stable(msb_first_out))
      else $error("mode changed while busy");
   a_slow_undiv: assert property (clk_src_out == SRC_LOW_SPEED |-> clk_div_out == DIV_NONE)
      else $error("slow source divided");
   a_etu_gap: assert property (etu_tick_out && s_q.rate == 11'h002 && s_q.en
                               ##1 (s_q.rate == 11'h002 && s_q.en) [*2]
                               |=> etu_tick_out)
      else $error("etu period not rate factor plus one");
   a_tbe_set: assert property (run_q && tx_load_in
                               |=> s_q.flags[FL_TBE])
      else $error("buffer empty flag not set on shifter load");
   // pins trail the mode bits by one register stage
   a_od_release: assert property (s_q.mode[MODE_DRIVE_TYPE]
                                  |=> !data_line_out)
      else $error("open drain line driven high");
   a_cclk_idle: assert property (s_q.mode[MODE_MST] && !s_q.clkout |=> card_clock_pin_oe_out
                                 && card_clock_pin_out == $past(s_q.mode[MODE_IDLE_CLOCK_LEVEL]))
      else $error("idle card clock level wrong");
   a_rate_write: assert property (run_q && wr_at(ADDR_RATE)
                                  |=> rate_factor_out == $past(reg_wdata_in[RATE_W-1:0]))
      else $error("rate factor write lost");
endmodule

/* test/scfc_card_model.sv */
// card side of the card data line: a pulled-up wire and a card that can pull it low
// assumes the design drives the line registered, open drain or push-pull
module scfc_card_model (
   input  wire logic drv_level_in,
   input  wire logic drv_enable_in,
   input  wire logic card_pull_low_in,
   output logic      line_level_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // wire resolution
   // ----------------------------------------
   // a released line floats up to the pull-up; any low driver wins the wire
   always_comb begin
      if (card_pull_low_in || (drv_enable_in && !drv_level_in)) begin
         line_level_out = 1'b0;
      end else begin
         line_level_out = 1'b1;
      end
   end
endmodule

/* test/smart_card_flags_and_config_bench.sv */
// self-checking bench for the card interface flag and configuration block
// assumes scfc_pkg, scfc_core and scfc_card_model are compiled before it
module smart_card_flags_and_config_bench import scfc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic [4:0]  ev = 5'h00;
   logic [7:0]  rx_byte = 8'h00;
   logic        rx_par = 1'b0, rx_busy = 1'b0, tx_busy = 1'b0, dbg = 1'b0, cclk = 1'b0;
   logic        tx_bit = 1'b0, tx_drv = 1'b0, card_low = 1'b0;
   logic [15:0] rdata;
   logic [10:0] rate;
   logic [7:0]  txd;
   logic [1:0]  csrc, cdiv;
   logic        irq, srst, crun, t1, oddp, msbf, etu, txrdy, rxbit;
   logic        dl_out, dl_oe, cp_out, cp_oe, line, lvl;
   int          n_fail = 0, checks_done = 0, i, m, b, k, first, gap;

   scfc_core i_dut (
      .sys_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .wait_elapsed_in(ev[0]),
      .tx_paused_in(ev[1]), .err_signal_in(ev[2]), .rx_done_in(ev[3]), .rx_byte_in(rx_byte),
      .rx_parity_in(rx_par), .tx_load_in(ev[4]), .rx_busy_in(rx_busy), .tx_busy_in(tx_busy),
      .debug_mode_in(dbg), .card_clk_in(cclk), .tx_bit_in(tx_bit), .tx_drive_in(tx_drv),
      .data_line_in(line), .irq_out(irq), .soft_reset_out(srst), .clk_src_out(csrc),
      .clk_div_out(cdiv), .clk_run_out(crun), .protocol_t1_out(t1), .odd_parity_out(oddp),
      .msb_first_out(msbf), .rate_factor_out(rate), .etu_tick_out(etu), .tx_data_out(txd),
      .tx_ready_out(txrdy), .rx_bit_out(rxbit), .data_line_out(dl_out),
      .data_line_oe_out(dl_oe), .card_clock_pin_out(cp_out), .card_clock_pin_oe_out(cp_oe));
   scfc_card_model i_card (.drv_level_in(dl_out), .drv_enable_in(dl_oe),
      .card_pull_low_in(card_low), .line_level_out(line));

   initial begin
      forever #50 clk = ~clk;
   end
   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] msk, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata & msk, exp);
   endtask
   task automatic pulse(input int n);
      @(posedge clk);
      ev[n] <= 1'b1;
      @(posedge clk);
      ev[n] <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rx_push(input logic [7:0] d, input logic p);
      @(posedge clk);
      rx_byte <= d;
      rx_par <= p;
      ev[3] <= 1'b1;
      @(posedge clk);
      ev[3] <= 1'b0;
      @(negedge clk);
   endtask
   task print_verdict;
      if (n_fail == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(ADDR_CLK, 16'hFFFF, 16'h0000);
      rd_reg(ADDR_MODE, 16'hFFFF, 16'h0005);
      rd_reg(ADDR_RATE, 16'hFFFF, 16'h0173);
      rd_reg(ADDR_FLAG, 16'hFFFF, 16'h0080);
      rd_reg(4'h9, 16'hFFFF, 16'h0000);
      wr_reg(ADDR_RATE, 16'hFFFF);
      rd_reg(ADDR_RATE, 16'hFFFF, 16'h07FF);
      chk({5'h00, rate}, 16'h07FF);
      wr_reg(ADDR_RATE, 16'h0002);
      for (i = 0; i < 4; i++) begin
         wr_reg(ADDR_CLK, 16'(i) | 16'h0030);
         @(negedge clk);
         chk({14'h0, csrc}, 16'(i));
         chk({14'h0, cdiv}, (i % 2 == 1) ? 16'h0000 : 16'h0003);
      end
      wr_reg(ADDR_CLK, 16'h0100);
      rd_reg(ADDR_CLK, 16'hFFFF, 16'h0100);
      @(posedge clk);
      dbg <= 1'b1;
      wr_reg(ADDR_CTL, 16'h0001);
      wr_reg(ADDR_CLK, 16'h0000);
      rd_reg(ADDR_CLK, 16'hFFFF, 16'h0100);
      chk({15'h0, crun}, 16'h0001);
      wr_reg(ADDR_CTL, 16'h0000);
      wr_reg(ADDR_CLK, 16'h0000);
      wr_reg(ADDR_CTL, 16'h0001);
      @(negedge clk);
      chk({15'h0, crun}, 16'h0000);
      @(posedge clk);
      dbg <= 1'b0;
      @(negedge clk);
      chk({15'h0, crun}, 16'h0001);
      // tick spacing measured between two ticks; bounded so a dead counter ends the run
      first = -1;
      gap = 0;
      for (k = 0; k < 100 && gap == 0; k++) begin
         @(negedge clk);
         if (etu === 1'b1 && first >= 0) gap = k - first;
         if (etu === 1'b1) first = k;
      end
      chk(16'(gap), 16'h0003);
      if (gap == 0) print_verdict();
      wr_reg(ADDR_MODE, 16'h00FF);
      rd_reg(ADDR_MODE, 16'hFFFF, 16'h00F7);
      chk({13'h0, t1, oddp, msbf}, 16'h0007);
      @(posedge clk);
      rx_busy <= 1'b1;
      wr_reg(ADDR_MODE, 16'h0005);
      rd_reg(ADDR_MODE, 16'hFFFF, 16'h00F7);
      @(posedge clk);
      rx_busy <= 1'b0;
      wr_reg(ADDR_MODE, 16'h0007);
      rd_reg(ADDR_MODE, 16'hFFFF, 16'h0007);
      chk({13'h0, t1, oddp, msbf}, 16'h0000);
      chk({14'h0, cp_oe, cp_out}, 16'h0003);
      wr_reg(ADDR_MODE, 16'h0005);
      repeat (2) @(negedge clk);
      chk({14'h0, cp_oe, cp_out}, 16'h0002);
      @(posedge clk);
      cclk <= 1'b1;
      wr_reg(ADDR_CTL, 16'h0401);
      repeat (2) @(negedge clk);
      chk({15'h0, cp_out}, 16'h0001);
      wr_reg(ADDR_MODE, 16'h0004);
      repeat (2) @(negedge clk);
      chk({15'h0, cp_oe}, 16'h0000);
      wr_reg(ADDR_CTL, 16'h0001);
      // m bit 0 inverts the line, m bit 1 picks open drain
      for (m = 0; m < 4; m++) begin
         for (b = 0; b < 2; b++) begin
            @(posedge clk);
            tx_bit <= b[0];
            tx_drv <= 1'b1;
            wr_reg(ADDR_MODE, 16'h0001 | (m[0] ? 16'h0020 : 16'h0) | (m[1] ? 16'h0004 : 16'h0));
            repeat (5) @(negedge clk);
            lvl = b[0] ^ m[0];
            chk({15'h0, dl_oe}, m[1] ? {15'h0, ~lvl} : 16'h0001);
            chk({14'h0, line, rxbit}, {14'h0, lvl, b[0]});
         end
      end
      @(posedge clk);
      tx_drv <= 1'b0;
      card_low <= 1'b1;
      repeat (5) @(negedge clk);
      chk({15'h0, rxbit}, 16'h0001);
      @(posedge clk);
      card_low <= 1'b0;
      wr_reg(ADDR_MODE, 16'h0005);
      wr_reg(ADDR_INTEN, 16'h00FF);
      pulse(0);
      rd_reg(ADDR_FLAG, 16'h00FF, 16'h00C0);
      chk({15'h0, irq}, 16'h0001);
      wr_reg(ADDR_FLAG, 16'h0040);
      pulse(2);
      rd_reg(ADDR_FLAG, 16'h00FF, 16'h0090);
      wr_reg(ADDR_FLAG, 16'h0000);
      rd_reg(ADDR_FLAG, 16'h00FF, 16'h0090);
      wr_reg(ADDR_INTEN, 16'h0001);
      @(negedge clk);
      chk({15'h0, irq}, 16'h0000);
      wr_reg(ADDR_FLAG, 16'h0010);
      rd_reg(ADDR_FLAG, 16'h00FF, 16'h0080);
      wr_reg(ADDR_TXD, 16'h00A5);
      pulse(1);
      rd_reg(ADDR_FLAG, 16'h00FF, 16'h0000);
      chk({7'h0, txrdy, txd}, 16'h01A5);
      pulse(4);
      pulse(1);
      rd_reg(ADDR_FLAG, 16'h00FF, 16'h00A0);
      wr_reg(ADDR_FLAG, 16'h0020);
      rx_push(8'h01, 1'b1);
      rd_reg(ADDR_FLAG, 16'h00FF, 16'h0081);
      rx_push(8'h03, 1'b0);
      rd_reg(ADDR_FLAG, 16'h00FF, 16'h0083);
      rx_push(8'h07, 1'b1);
      rd_reg(ADDR_FLAG, 16'h00FF, 16'h0087);
      rd_reg(ADDR_RXD, 16'hFFFF, 16'h0101);
      rd_reg(ADDR_RXD, 16'hFFFF, 16'h0003);
      rd_reg(ADDR_FLAG, 16'h0001, 16'h0000);
      rx_push(8'h01, 1'b0);
      rd_reg(ADDR_FLAG, 16'h0008, 16'h0008);
      wr_reg(ADDR_CTL, 16'h0003);
      @(negedge clk);
      chk({15'h0, srst}, 16'h0001);
      rd_reg(ADDR_FLAG, 16'h00FF, 16'h0080);
      rd_reg(ADDR_CTL, 16'h0003, 16'h0001);
      wr_reg(ADDR_MODE, 16'h0045);
      rx_push(8'h01, 1'b0);
      rd_reg(ADDR_FLAG, 16'h0009, 16'h0001);
      rx_push(8'h01, 1'b1);
      rd_reg(ADDR_FLAG, 16'h0008, 16'h0008);
      print_verdict();
   end
endmodule
